// ### rtl/avfc_defs.svh
`ifndef AVFC_DEFS_SVH
`define AVFC_DEFS_SVH
`define AVFC_A_RVL 12'h500
`define AVFC_A_RVR 12'h501
`define AVFC_A_PVL 12'h502
`define AVFC_A_PVR 12'h503
`define AVFC_A_RFC 12'h510
`define AVFC_A_PFC 12'h520
`define AVFC_A_STS 12'h5F0
`define AVFC_B_VU 8
`define AVFC_B_CUTH 14
`define AVFC_B_CUTL 13
`define AVFC_B_HPL 12
`define AVFC_B_HPR 11
`define AVFC_B_MUTE 9
`define AVFC_B_MONO 7
`define AVFC_B_RATE 5
`define AVFC_B_URMP 4
`define AVFC_RST_VOL 8'hC0
`define AVFC_RST_RFC 16'h0000
`define AVFC_RST_PFC 16'h0200
`define AVFC_REC_MAX 8'hEF
`define AVFC_PLAY_MAX 8'hC0
`define AVFC_VOL_MUTE 8'h00
`define AVFC_COEF_HIFI 16'h0022
`define AVFC_COEF_V1 16'h1989
`define AVFC_COEF_V2 16'h1A24
`define AVFC_COEF_V3 16'h35AE
`define AVFC_RAMP_FAST 5'h01
`define AVFC_RAMP_SLOW 5'h1F
`define AVFC_LVL_FULL 9'h100
`define AVFC_UNITY_SHIFT 6'h1B
`endif

// ### rtl/avfc_pkg.sv
package avfc_pkg;
  typedef logic signed [23:0] avfc_sample_type;
  typedef enum logic [1:0]
  {
    AVFC_MUTED = 2'b00,
    AVFC_RISE = 2'b01,
    AVFC_OPEN = 2'b11,
    AVFC_FALL = 2'b10
  } avfc_ramp_type;
endpackage : avfc_pkg

// ### rtl/avfc_chan_if.sv
`timescale 1ns/10ps
interface avfc_chan_if;
  avfc_pkg::avfc_sample_type left;
  avfc_pkg::avfc_sample_type right;
  logic valid;
  modport src (output left, output right, output valid);
  modport dst (input left, input right, input valid);
endinterface : avfc_chan_if

// ### rtl/avfc_gain.sv
`timescale 1ns/10ps
`include "avfc_defs.svh"
module avfc_gain
#(
  parameter logic [7:0] MAX_CODE = 8'hFF
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic in_valid,
  input wire avfc_pkg::avfc_sample_type in_data,
  input wire logic [7:0] code,
  output logic out_valid,
  output avfc_pkg::avfc_sample_type out_data
);
  logic [7:0] eff;
  logic [15:0] mant;
  logic signed [40:0] prod;
  logic signed [40:0] scaled;
  avfc_pkg::avfc_sample_type sat;

  // Codes above the top of the scale hold the top gain
  assign eff = (code > MAX_CODE) ? MAX_CODE : code;

  // Sixteen codes double the gain; low nibble picks the mantissa
  always_comb
  begin
    case (eff[3:0])
      4'h0: mant = 16'h8000;
      4'h1: mant = 16'h85AB;
      4'h2: mant = 16'h8B96;
      4'h3: mant = 16'h91C4;
      4'h4: mant = 16'h9838;
      4'h5: mant = 16'h9EF5;
      4'h6: mant = 16'hA5FF;
      4'h7: mant = 16'hAD58;
      4'h8: mant = 16'hB505;
      4'h9: mant = 16'hBD09;
      4'hA: mant = 16'hC567;
      4'hB: mant = 16'hCE24;
      4'hC: mant = 16'hD745;
      4'hD: mant = 16'hE0CD;
      4'hE: mant = 16'hEAC1;
      default: mant = 16'hF525;
    endcase
  end

  assign prod = in_data * $signed({1'b0, mant});
  assign scaled = prod >>> (`AVFC_UNITY_SHIFT - {2'b00, eff[7:4]});

  always_comb
  begin
    if (scaled > 41'sh7FFFFF)
      sat = 24'sh7FFFFF;
    else if (scaled < -41'sh800000)
      sat = -24'sh800000;
    else
      sat = scaled[23:0];
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      out_valid <= 1'b0;
      out_data <= 24'h000000;
    end
    else
    begin
      out_valid <= in_valid;
      if (in_valid)
        out_data <= (eff == `AVFC_VOL_MUTE) ? 24'h000000 : sat;
    end
  end

  AST_GAIN_MUTE: assert property (@(posedge mclk) disable iff (rst)
    in_valid && code == 8'h00 |=> out_valid && out_data == 24'h000000)
    else $error("Mute code did not give silence");

  AST_GAIN_UNITY: assert property (@(posedge mclk) disable iff (rst)
    in_valid && code >= 8'hC0 && MAX_CODE == 8'hC0 |=> out_data == $past(in_data))
    else $error("Playback code at or above C0 is not unity");
endmodule : avfc_gain

// ### rtl/avfc_hpf.sv
`timescale 1ns/10ps
`include "avfc_defs.svh"
module avfc_hpf
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic in_valid,
  input wire avfc_pkg::avfc_sample_type in_l,
  input wire avfc_pkg::avfc_sample_type in_r,
  input wire logic [1:0] cut,
  input wire logic en_l,
  input wire logic en_r,
  avfc_chan_if.src out
);
  logic [15:0] coef;
  avfc_pkg::avfc_sample_type x_in [2];
  avfc_pkg::avfc_sample_type y_out [2];
  logic en [2];
  logic valid_ff;

  // Leak coefficient sets the corner; corner scales with fs
  always_comb
  begin
    case (cut)
      2'b00: coef = `AVFC_COEF_HIFI;
      2'b01: coef = `AVFC_COEF_V1;
      2'b10: coef = `AVFC_COEF_V2;
      default: coef = `AVFC_COEF_V3;
    endcase
  end

  assign x_in[0] = in_l;
  assign x_in[1] = in_r;
  assign en[0] = en_l;
  assign en[1] = en_r;

  genvar i;
  generate
    for (i = 0; i < 2; i++)
    begin : g_ch
      logic signed [25:0] xp_ff;
      logic signed [25:0] y_ff;
      logic signed [25:0] nxt_y;
      logic signed [42:0] prod;
      avfc_pkg::avfc_sample_type yo_ff;
      assign prod = y_ff * $signed({1'b0, coef});
      assign nxt_y = 26'(x_in[i]) - xp_ff + y_ff - $signed(prod[41:16]);
      // Previous input is tracked while bypassed so enabling gives no step
      always_ff @(posedge mclk)
      begin
        if (rst)
        begin
          xp_ff <= 26'h0000000;
          y_ff <= 26'h0000000;
          yo_ff <= 24'h000000;
        end
        else if (in_valid)
        begin
          xp_ff <= 26'(x_in[i]);
          if (en[i])
          begin
            y_ff <= nxt_y;
            if (nxt_y[25:23] == 3'b000 || nxt_y[25:23] == 3'b111)
              yo_ff <= nxt_y[23:0];
            else
              yo_ff <= {nxt_y[25], {23{~nxt_y[25]}}};
          end
          else
          begin
            y_ff <= 26'h0000000;
            yo_ff <= x_in[i];
          end
        end
      end
      assign y_out[i] = yo_ff;
    end
  endgenerate

  always_ff @(posedge mclk)
  begin
    if (rst)
      valid_ff <= 1'b0;
    else
      valid_ff <= in_valid;
  end

  assign out.left = y_out[0];
  assign out.right = y_out[1];
  assign out.valid = valid_ff;

  AST_HPF_BYPASS_L: assert property (@(posedge mclk) disable iff (rst)
    in_valid && !en_l |=> out.valid && out.left == $past(in_l))
    else $error("Left record filter not bypassed while off");

  AST_HPF_BYPASS_R: assert property (@(posedge mclk) disable iff (rst)
    in_valid && !en_r |=> out.valid && out.right == $past(in_r))
    else $error("Right record filter not bypassed while off");
endmodule : avfc_hpf

// ### rtl/avfc_top.sv
// Added by the designer: strobed register access.
`timescale 1ns/10ps
`include "avfc_defs.svh"
// Operation
// - Record update bit applies both pending record gains together
// - Playback update bit applies both pending playback gains together
// - Record left gain: 00h mute, 01h -71.625dB, 0.375dB steps, EFh top
// - Record right gain same coding; both reset to C0h
// - Playback left gain: 00h mute, 0.375dB steps, C0h to FFh unity
// - Playback right gain same coding; both reset to C0h
// - Record high-pass corner chosen by two-bit field, hi-fi or three voice
// - Left record high-pass only while its enable is set; off at reset
// - Right record high-pass only while its enable is set; off at reset
// - Playback soft-muted while mute bit set; muted after reset
// - Mono bit mixes left and right playback; separate at reset
// - Ramp rate bit: fast step every 2 samples, slow every 32
// - Unmute jumps to volume, or ramps up when ramp select set
module avfc_top
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [11:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rd_data,
  input wire logic rec_in_valid,
  input wire avfc_pkg::avfc_sample_type rec_in_left,
  input wire avfc_pkg::avfc_sample_type rec_in_right,
  output logic rec_out_valid,
  output avfc_pkg::avfc_sample_type rec_out_left,
  output avfc_pkg::avfc_sample_type rec_out_right,
  input wire logic play_in_valid,
  input wire avfc_pkg::avfc_sample_type play_in_left,
  input wire avfc_pkg::avfc_sample_type play_in_right,
  output logic play_out_valid,
  output avfc_pkg::avfc_sample_type play_out_left,
  output avfc_pkg::avfc_sample_type play_out_right
);
  // A literal cannot be bit-selected, so reset words are held as constants first
  localparam logic [15:0] RST_RFC = `AVFC_RST_RFC;
  localparam logic [15:0] RST_PFC = `AVFC_RST_PFC;
  logic [7:0] rec_left_gain_ff, rec_right_gain_ff, play_left_gain_ff, play_right_gain_ff;
  logic [7:0] rec_left_act_ff, rec_right_act_ff, play_left_act_ff, play_right_act_ff;
  logic [1:0] record_highpass_cutoff_ff;
  logic record_left_highpass_enable_ff, record_right_highpass_enable_ff, playback_soft_mute_ff;
  logic playback_mono_mix_ff, playback_mute_ramp_rate_ff, playback_unmute_ramp_select_ff;
  logic [15:0] rd_data_ff, nxt_rd_data;
  logic wr_rvl, wr_rvr, wr_pvl, wr_pvr, record_volume_update, playback_volume_update;
  logic [7:0] nxt_rec_left, nxt_rec_right, nxt_play_left, nxt_play_right;
  avfc_pkg::avfc_ramp_type state_ff, nxt_state;
  logic [8:0] level_ff;
  logic [4:0] div_ff, div_target;
  logic ramping, step, rg_l_valid, rg_r_valid, pg_l_valid, pg_r_valid;
  avfc_pkg::avfc_sample_type rg_l, rg_r, pg_l, pg_r, mix_l, mix_r;
  logic signed [24:0] mono_sum;
  logic signed [33:0] att_l, att_r;
  logic rec_out_valid_ff, play_out_valid_ff;
  avfc_pkg::avfc_sample_type rec_out_left_ff, rec_out_right_ff, play_out_left_ff, play_out_right_ff;

  avfc_chan_if hp_if ();

  assign wr_rvl = wr_en && addr == `AVFC_A_RVL;
  assign wr_rvr = wr_en && addr == `AVFC_A_RVR;
  assign wr_pvl = wr_en && addr == `AVFC_A_PVL;
  assign wr_pvr = wr_en && addr == `AVFC_A_PVR;
  assign record_volume_update = (wr_rvl || wr_rvr) && wr_data[`AVFC_B_VU];
  assign playback_volume_update = (wr_pvl || wr_pvr) && wr_data[`AVFC_B_VU];

  // The word carrying the update bit also lands in its own channel
  assign nxt_rec_left = wr_rvl ? wr_data[7:0] : rec_left_gain_ff;
  assign nxt_rec_right = wr_rvr ? wr_data[7:0] : rec_right_gain_ff;
  assign nxt_play_left = wr_pvl ? wr_data[7:0] : play_left_gain_ff;
  assign nxt_play_right = wr_pvr ? wr_data[7:0] : play_right_gain_ff;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rec_left_gain_ff <= `AVFC_RST_VOL;
      rec_right_gain_ff <= `AVFC_RST_VOL;
      play_left_gain_ff <= `AVFC_RST_VOL;
      play_right_gain_ff <= `AVFC_RST_VOL;
    end
    else
    begin
      rec_left_gain_ff <= nxt_rec_left;
      rec_right_gain_ff <= nxt_rec_right;
      play_left_gain_ff <= nxt_play_left;
      play_right_gain_ff <= nxt_play_right;
    end
  end

  // Both channels switch in one edge so the stereo image never skews
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rec_left_act_ff <= `AVFC_RST_VOL;
      rec_right_act_ff <= `AVFC_RST_VOL;
      play_left_act_ff <= `AVFC_RST_VOL;
      play_right_act_ff <= `AVFC_RST_VOL;
    end
    else
    begin
      if (record_volume_update)
      begin
        rec_left_act_ff <= nxt_rec_left;
        rec_right_act_ff <= nxt_rec_right;
      end
      if (playback_volume_update)
      begin
        play_left_act_ff <= nxt_play_left;
        play_right_act_ff <= nxt_play_right;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      record_highpass_cutoff_ff <= RST_RFC[`AVFC_B_CUTH:`AVFC_B_CUTL];
      record_left_highpass_enable_ff <= RST_RFC[`AVFC_B_HPL];
      record_right_highpass_enable_ff <= RST_RFC[`AVFC_B_HPR];
    end
    else if (wr_en && addr == `AVFC_A_RFC)
    begin
      record_highpass_cutoff_ff <= wr_data[`AVFC_B_CUTH:`AVFC_B_CUTL];
      record_left_highpass_enable_ff <= wr_data[`AVFC_B_HPL];
      record_right_highpass_enable_ff <= wr_data[`AVFC_B_HPR];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      playback_soft_mute_ff <= RST_PFC[`AVFC_B_MUTE];
      playback_mono_mix_ff <= RST_PFC[`AVFC_B_MONO];
      playback_mute_ramp_rate_ff <= RST_PFC[`AVFC_B_RATE];
      playback_unmute_ramp_select_ff <= RST_PFC[`AVFC_B_URMP];
    end
    else if (wr_en && addr == `AVFC_A_PFC)
    begin
      playback_soft_mute_ff <= wr_data[`AVFC_B_MUTE];
      playback_mono_mix_ff <= wr_data[`AVFC_B_MONO];
      playback_mute_ramp_rate_ff <= wr_data[`AVFC_B_RATE];
      playback_unmute_ramp_select_ff <= wr_data[`AVFC_B_URMP];
    end
  end

  // Update bits are strobes and always read back as zero
  always_comb
  begin
    case (addr)
      `AVFC_A_RVL: nxt_rd_data = {8'h00, rec_left_gain_ff};
      `AVFC_A_RVR: nxt_rd_data = {8'h00, rec_right_gain_ff};
      `AVFC_A_PVL: nxt_rd_data = {8'h00, play_left_gain_ff};
      `AVFC_A_PVR: nxt_rd_data = {8'h00, play_right_gain_ff};
      `AVFC_A_RFC: nxt_rd_data = {1'b0, record_highpass_cutoff_ff, record_left_highpass_enable_ff,
        record_right_highpass_enable_ff, 11'h000};
      `AVFC_A_PFC: nxt_rd_data = {6'h00, playback_soft_mute_ff, 1'b0, playback_mono_mix_ff, 1'b0,
        playback_mute_ramp_rate_ff, playback_unmute_ramp_select_ff, 4'h0};
      `AVFC_A_STS: nxt_rd_data = {2'b00, state_ff, 3'b000, level_ff};
      default: nxt_rd_data = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      rd_data_ff <= 16'h0000;
    else
      rd_data_ff <= rd_en ? nxt_rd_data : 16'h0000;
  end

  assign rd_data = rd_data_ff;

  // Soft mute ramp: the attenuation level moves one step per divided sample tick
  assign ramping = state_ff == avfc_pkg::AVFC_RISE || state_ff == avfc_pkg::AVFC_FALL;
  assign div_target = playback_mute_ramp_rate_ff ? `AVFC_RAMP_SLOW : `AVFC_RAMP_FAST;
  assign step = ramping && play_in_valid && div_ff == div_target;

  always_ff @(posedge mclk)
  begin
    if (rst || !ramping || step)
      div_ff <= 5'h00;
    else if (play_in_valid)
      div_ff <= div_ff + 5'h01;
  end

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      avfc_pkg::AVFC_MUTED:
        if (!playback_soft_mute_ff)
          nxt_state = playback_unmute_ramp_select_ff ? avfc_pkg::AVFC_RISE : avfc_pkg::AVFC_OPEN;
      avfc_pkg::AVFC_RISE:
        if (playback_soft_mute_ff)
          nxt_state = avfc_pkg::AVFC_FALL;
        else if (step && level_ff == `AVFC_LVL_FULL - 9'h001)
          nxt_state = avfc_pkg::AVFC_OPEN;
      avfc_pkg::AVFC_OPEN:
        if (playback_soft_mute_ff)
          nxt_state = avfc_pkg::AVFC_FALL;
      avfc_pkg::AVFC_FALL:
        if (!playback_soft_mute_ff)
          nxt_state = playback_unmute_ramp_select_ff ? avfc_pkg::AVFC_RISE : avfc_pkg::AVFC_OPEN;
        else if (step && level_ff <= 9'h001)
          nxt_state = avfc_pkg::AVFC_MUTED;
      default:
        nxt_state = avfc_pkg::AVFC_MUTED;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      state_ff <= avfc_pkg::AVFC_MUTED;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      level_ff <= 9'h000;
    else if (nxt_state == avfc_pkg::AVFC_OPEN)
      level_ff <= `AVFC_LVL_FULL;
    else if (nxt_state == avfc_pkg::AVFC_MUTED)
      level_ff <= 9'h000;
    else if (step && state_ff == avfc_pkg::AVFC_RISE && nxt_state == avfc_pkg::AVFC_RISE)
      level_ff <= level_ff + 9'h001;
    else if (step && state_ff == avfc_pkg::AVFC_FALL && level_ff != 9'h000)
      level_ff <= level_ff - 9'h001;
  end

  avfc_hpf u_hpf
  (.mclk(mclk), .rst(rst), .in_valid(rec_in_valid), .in_l(rec_in_left), .in_r(rec_in_right),
    .cut(record_highpass_cutoff_ff), .en_l(record_left_highpass_enable_ff),
    .en_r(record_right_highpass_enable_ff), .out(hp_if.src));

  avfc_gain #(.MAX_CODE(`AVFC_REC_MAX)) u_rec_l
  (.mclk(mclk), .rst(rst), .in_valid(hp_if.valid), .in_data(hp_if.left), .code(rec_left_act_ff),
    .out_valid(rg_l_valid), .out_data(rg_l));
  avfc_gain #(.MAX_CODE(`AVFC_REC_MAX)) u_rec_r
  (.mclk(mclk), .rst(rst), .in_valid(hp_if.valid), .in_data(hp_if.right), .code(rec_right_act_ff),
    .out_valid(rg_r_valid), .out_data(rg_r));
  avfc_gain #(.MAX_CODE(`AVFC_PLAY_MAX)) u_play_l
  (.mclk(mclk), .rst(rst), .in_valid(play_in_valid), .in_data(play_in_left), .code(play_left_act_ff),
    .out_valid(pg_l_valid), .out_data(pg_l));
  avfc_gain #(.MAX_CODE(`AVFC_PLAY_MAX)) u_play_r
  (.mclk(mclk), .rst(rst), .in_valid(play_in_valid), .in_data(play_in_right), .code(play_right_act_ff),
    .out_valid(pg_r_valid), .out_data(pg_r));

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rec_out_valid_ff <= 1'b0;
      rec_out_left_ff <= 24'h000000;
      rec_out_right_ff <= 24'h000000;
    end
    else
    begin
      rec_out_valid_ff <= rg_l_valid && rg_r_valid;
      if (rg_l_valid)
        rec_out_left_ff <= rg_l;
      if (rg_r_valid)
        rec_out_right_ff <= rg_r;
    end
  end

  // Halving the sum avoids clipping when both channels are at full scale
  assign mono_sum = {pg_l[23], pg_l} + {pg_r[23], pg_r};
  assign mix_l = playback_mono_mix_ff ? mono_sum[24:1] : pg_l;
  assign mix_r = playback_mono_mix_ff ? mono_sum[24:1] : pg_r;
  assign att_l = mix_l * $signed({1'b0, level_ff});
  assign att_r = mix_r * $signed({1'b0, level_ff});

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      play_out_valid_ff <= 1'b0;
      play_out_left_ff <= 24'h000000;
      play_out_right_ff <= 24'h000000;
    end
    else
    begin
      play_out_valid_ff <= pg_l_valid && pg_r_valid;
      if (pg_l_valid)
      begin
        play_out_left_ff <= att_l[31:8];
        play_out_right_ff <= att_r[31:8];
      end
    end
  end

  assign rec_out_valid = rec_out_valid_ff;
  assign rec_out_left = rec_out_left_ff;
  assign rec_out_right = rec_out_right_ff;
  assign play_out_valid = play_out_valid_ff;
  assign play_out_left = play_out_left_ff;
  assign play_out_right = play_out_right_ff;

  AST_REC_VU: assert property (@(posedge mclk) disable iff (rst)
    wr_rvl && wr_data[8] |=> rec_left_act_ff == $past(wr_data[7:0]) && rec_right_act_ff == rec_right_gain_ff)
    else $error("Record update did not apply both gains");

  AST_PLAY_VU: assert property (@(posedge mclk) disable iff (rst)
    wr_pvr && wr_data[8] |=> play_right_act_ff == $past(wr_data[7:0]) && play_left_act_ff == play_left_gain_ff)
    else $error("Playback update did not apply both gains");

  AST_REC_HOLD: assert property (@(posedge mclk) disable iff (rst)
    !record_volume_update |=> $stable(rec_left_act_ff) && $stable(rec_right_act_ff))
    else $error("Record gain changed without update");

  AST_UNMUTE_NOW: assert property (@(posedge mclk) disable iff (rst)
    state_ff == avfc_pkg::AVFC_MUTED && !playback_soft_mute_ff && !playback_unmute_ramp_select_ff
    |=> level_ff == 9'h100 && state_ff == avfc_pkg::AVFC_OPEN)
    else $error("Unmute without ramp did not jump to full");

  AST_RAMP_FAST: assert property (@(posedge mclk) disable iff (rst)
    state_ff == avfc_pkg::AVFC_FALL && playback_soft_mute_ff && !playback_mute_ramp_rate_ff
    && play_in_valid && div_ff == 5'h01 && level_ff > 9'h001 |=> level_ff == $past(level_ff) - 9'h001)
    else $error("Fast ramp did not step on second sample");

  AST_MUTED_ZERO: assert property (@(posedge mclk) disable iff (rst)
    state_ff == avfc_pkg::AVFC_MUTED && pg_l_valid ##1 state_ff == avfc_pkg::AVFC_MUTED
    |-> play_out_left == 24'h000000 && play_out_right == 24'h000000)
    else $error("Playback not silent while muted");

  AST_MONO: assert property (@(posedge mclk) disable iff (rst)
    pg_l_valid && playback_mono_mix_ff |=> play_out_left == play_out_right)
    else $error("Mono mix channels differ");
endmodule : avfc_top

// ### bench/avfc_proc_model.sv
`timescale 1ns/10ps
module avfc_proc_model
(
  input wire logic mclk,
  output logic rec_valid = 1'b0,
  output logic play_valid = 1'b0,
  output avfc_pkg::avfc_sample_type left = 24'h000000,
  output avfc_pkg::avfc_sample_type right = 24'h000000
);
  // One stereo pair per strobe; both streams share the sample lines
  task send(input logic rec, input avfc_pkg::avfc_sample_type l, input avfc_pkg::avfc_sample_type r);
    @(posedge mclk);
    rec_valid <= rec;
    play_valid <= !rec;
    left <= l;
    right <= r;
    @(posedge mclk);
    rec_valid <= 1'b0;
    play_valid <= 1'b0;
    // Inverted lines outside the strobe expose any stale capture
    left <= ~l;
    right <= ~r;
  endtask : send
endmodule : avfc_proc_model

// ### bench/avfc_top_tb.sv
`timescale 1ns/10ps
`include "avfc_defs.svh"
module avfc_top_tb;
  localparam avfc_pkg::avfc_sample_type X = 24'h100000;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] addr = 12'h000;
  logic [15:0] wr_data = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [15:0] rd_data;
  logic rv, pv, rov, pov;
  avfc_pkg::avfc_sample_type sl, sr, rol, ror, pol, por, ol, orr;
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [15:0] hp_coef [4] = '{`AVFC_COEF_HIFI, `AVFC_COEF_V1, `AVFC_COEF_V2, `AVFC_COEF_V3};
  avfc_proc_model proc (.mclk(mclk), .rec_valid(rv), .play_valid(pv), .left(sl), .right(sr));
  avfc_top DUT (.mclk(mclk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .rec_in_valid(rv), .rec_in_left(sl), .rec_in_right(sr), .rec_out_valid(rov),
    .rec_out_left(rol), .rec_out_right(ror), .play_in_valid(pv), .play_in_left(sl), .play_in_right(sr),
    .play_out_valid(pov), .play_out_left(pol), .play_out_right(por));
  initial
  begin
    forever #2 mclk = ~mclk;
  end
  // Ramp scenarios dominate run time; about 5k cycles expected
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_mismatch++;
      report_and_stop;
    end
  end
  task report_and_stop;
    $display("Compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task check(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask : wr
  task rd(input logic [11:0] a, input logic [15:0] exp);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    check(rd_data, exp);
  endtask : rd
  task xfer(input logic rec, input avfc_pkg::avfc_sample_type l, input avfc_pkg::avfc_sample_type r);
    int i;
    proc.send(rec, l, r);
    for (i = 0; i < 8; i++)
    begin
      @(posedge mclk);
      #1;
      if ((rec ? rov : pov) === 1'b1)
        break;
    end
    if (i == 8)
      check(1'b0, 1'b1);
    ol = rec ? rol : pol;
    orr = rec ? ror : por;
  endtask : xfer
  task t_reset_values;
    rd(`AVFC_A_RVL, 16'h00C0);
    rd(`AVFC_A_RVR, 16'h00C0);
    rd(`AVFC_A_PVL, 16'h00C0);
    rd(`AVFC_A_PVR, 16'h00C0);
    rd(`AVFC_A_RFC, 16'h0000);
    rd(`AVFC_A_PFC, 16'h0200);
    rd(`AVFC_A_STS, 16'h0000);
    rd(12'h5FF, 16'h0000);
  endtask : t_reset_values
  task t_playback;
    xfer(1'b0, X, X);
    check(ol, 24'h000000);
    wr(`AVFC_A_PFC, 16'h0000);
    xfer(1'b0, X, X);
    check(ol, X);
    wr(`AVFC_A_PVL, 16'h00FF);
    wr(`AVFC_A_PVR, 16'h0000);
    xfer(1'b0, X, X);
    check(ol, X);
    check(orr, X);
    wr(`AVFC_A_PVL, 16'h01FF);
    xfer(1'b0, X, X);
    check(ol, X);
    check(orr, 24'h000000);
    wr(`AVFC_A_PVR, 16'h01C0);
    wr(`AVFC_A_PFC, 16'h0080);
    xfer(1'b0, 24'h100000, 24'h300000);
    check(ol, 24'h200000);
    check(orr, 24'h200000);
    wr(`AVFC_A_PFC, 16'h0000);
  endtask : t_playback
  task t_record;
    int c;
    wr(`AVFC_A_RVL, 16'h0000);
    xfer(1'b1, X, X);
    check(ol, X);
    wr(`AVFC_A_RVR, 16'h01D0);
    xfer(1'b1, X, X);
    check(ol, 24'h000000);
    check(orr, 24'h200000);
    wr(`AVFC_A_RVR, 16'h00C0);
    wr(`AVFC_A_RVL, 16'h01C0);
    // A zero sample with the filter off clears its state, so every corner sees the same step
    for (c = 0; c < 4; c++)
    begin
      wr(`AVFC_A_RFC, {1'b0, c[1:0], 13'h0000});
      xfer(1'b1, 24'h000000, 24'h000000);
      wr(`AVFC_A_RFC, {1'b0, c[1:0], 1'b1, 12'h000});
      xfer(1'b1, X, X);
      check(ol, X);
      xfer(1'b1, X, X);
      check(ol, X - {4'h0, hp_coef[c], 4'h0});
      check(orr, X);
    end
    wr(`AVFC_A_RFC, 16'h0800);
    xfer(1'b1, X, X);
    xfer(1'b1, X, X);
    check(ol, X);
    check(orr, 24'h000000);
    wr(`AVFC_A_RFC, 16'h0000);
  endtask : t_record
  task t_ramp;
    wr(`AVFC_A_PFC, 16'h0200);
    xfer(1'b0, X, X);
    check(ol, X);
    repeat (520) xfer(1'b0, X, X);
    check(ol, 24'h000000);
    rd(`AVFC_A_STS, 16'h0000);
    wr(`AVFC_A_PFC, 16'h0010);
    xfer(1'b0, X, X);
    check(ol, 24'h000000);
    repeat (520) xfer(1'b0, X, X);
    check(ol, X);
    wr(`AVFC_A_PFC, 16'h0220);
    repeat (520) xfer(1'b0, X, X);
    check(ol, 24'h0F0000);
    rd(`AVFC_A_STS, 16'h20F0);
    wr(`AVFC_A_PFC, 16'h0000);
    xfer(1'b0, X, X);
    check(ol, X);
  endtask : t_ramp
  initial
  begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_reset_values;
    t_playback;
    t_record;
    t_ramp;
    report_and_stop;
  end
endmodule : avfc_top_tb
